// ==== core/sfes_host.sv ====
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module sfes_host #(
	parameter logic [sfes_pkg::CW-1:0] PROG_HOLD_CYC =
		sfes_pkg::CW'(sfes_pkg::PROG_HOLD_US * sfes_pkg::CLK_MHZ),
	parameter logic [sfes_pkg::CW-1:0] BULK_CYC =
		sfes_pkg::CW'(sfes_pkg::BULK_ERASE_US * sfes_pkg::CLK_MHZ)
)(
	// clock, reset, enable
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	// avalon-mm slave
	input  wire logic [2:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// programming pins
	output logic             prog_serial_clock_o,
	output logic             prog_serial_data_o,
	output logic             prog_serial_data_oe_o,
	input  wire logic        prog_serial_data_i
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {M_IDLE, M_ISSUE, M_WAIT, M_FIN} sfes_mst_t;

	sfes_mst_t    mst_q;
	logic [3:0]   idx_q;
	logic [1:0]   op_q;
	logic [7:0]   opt_q;
	logic [21:0]  row_q;
	logic         err_q;
	logic         panel_q;
	logic         ack_q;
	logic [31:0]  rdata_q;
	logic         sdat_s1_q;
	logic         sdat_s2_q;
	logic         acc_wr;
	logic         go;
	logic         go_ok;
	logic         busy;
	logic [1:0]   wop;
	logic [3:0]   st_cmd;
	logic [15:0]  st_pay;
	logic         st_ext;
	logic [1:0]   st_lo;
	logic         st_last;
	logic         sh_start;
	logic         sh_done;
	logic         sh_busy;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// six core instructions that load the table pointer
	function automatic logic [15:0] ptr_load(
		input logic [3:0] k, input logic [21:0] a);
		unique case (k)
			4'h0:    ptr_load = {sfes_pkg::OPC_MOVLW, 2'b00, a[21:16]};
			4'h1:    ptr_load = {sfes_pkg::OPC_MOVWF, sfes_pkg::REG_PTR_U};
			4'h2:    ptr_load = {sfes_pkg::OPC_MOVLW, a[15:8]};
			4'h3:    ptr_load = {sfes_pkg::OPC_MOVWF, sfes_pkg::REG_PTR_H};
			4'h4:    ptr_load = {sfes_pkg::OPC_MOVLW, a[7:0]};
			default: ptr_load = {sfes_pkg::OPC_MOVWF, sfes_pkg::REG_PTR_L};
		endcase
	endfunction

	// only the documented erase option codes are sent
	function automatic logic opt_ok(input logic [7:0] o);
		opt_ok = (o == sfes_pkg::OPT_CHIP) || (o == sfes_pkg::OPT_DATA)
			|| (o == sfes_pkg::OPT_BOOT)
			|| (o >= sfes_pkg::OPT_BLK_FIRST && o <= sfes_pkg::OPT_BLK_LAST);
	endfunction

	// ------------------------------------------------------------
	// avalon slave
	// ------------------------------------------------------------
	// one wait state on every access while ce_i is high; write lands on the ack edge
	always_ff @(posedge mclk_i) begin
		if (!nrst_i)
			ack_q <= 1'b0;
		else if (ce_i)
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
	end

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
	assign acc_wr            = avs_write_i & ack_q;
	assign busy              = (mst_q != M_IDLE);
	assign wop               = avs_writedata_i[1:0];

	// read word captured in the wait cycle, stands at the ack edge
	always_ff @(posedge mclk_i) begin
		if (!nrst_i)
			rdata_q <= '0;
		else if (ce_i && avs_read_i && !ack_q) begin
			unique case (avs_address_i)
				sfes_pkg::REG_CTRL:   rdata_q <= {30'h0, op_q};
				sfes_pkg::REG_OPTION: rdata_q <= {24'h0, opt_q};
				sfes_pkg::REG_ROW:    rdata_q <= {10'h0, row_q};
				sfes_pkg::REG_STATUS: rdata_q <= {28'h0, panel_q,
					sdat_s2_q, err_q, busy};
				default:              rdata_q <= '0;
			endcase
		end
	end

	assign avs_readdata_o = rdata_q;

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	// writes to control while busy are ignored, not queued
	assign go = acc_wr && avs_address_i == sfes_pkg::REG_CTRL
		&& mst_q == M_IDLE;
	assign go_ok = go && ((wop == sfes_pkg::OP_BULK && opt_ok(opt_q))
		|| wop == sfes_pkg::OP_SETUP
		|| (wop == sfes_pkg::OP_ROW && panel_q));

	// operation, option and row pointer
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			op_q  <= sfes_pkg::OP_BULK;
			opt_q <= sfes_pkg::OPTION_RST;
			row_q <= '0;
		end else if (ce_i) begin
			if (go_ok)
				op_q <= wop;
			if (acc_wr && !busy && avs_address_i == sfes_pkg::REG_OPTION)
				opt_q <= avs_writedata_i[7:0];
			// the same offset is kept from load to start
			if (acc_wr && !busy && avs_address_i == sfes_pkg::REG_ROW)
				row_q <= avs_writedata_i[21:0];
			else if (mst_q == M_FIN && op_q == sfes_pkg::OP_ROW)
				row_q <= row_q + sfes_pkg::ROW_STEP;
		end
	end

	// error flag: a refused start wins over a same-cycle clear
	always_ff @(posedge mclk_i) begin
		if (!nrst_i)
			err_q <= 1'b0;
		else if (ce_i) begin
			if (go && !go_ok)
				err_q <= 1'b1;
			else if (acc_wr && avs_address_i == sfes_pkg::REG_STATUS
				&& avs_writedata_i[sfes_pkg::ST_ERR])
				err_q <= 1'b0;
		end
	end

	// multi-panel mode known to be set up in the device
	always_ff @(posedge mclk_i) begin
		if (!nrst_i)
			panel_q <= 1'b0;
		else if (ce_i && mst_q == M_FIN && op_q == sfes_pkg::OP_SETUP)
			panel_q <= 1'b1;
	end

	// ------------------------------------------------------------
	// data pin synchroniser
	// ------------------------------------------------------------
	// pin is not on our clock, so two stages before status
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			sdat_s1_q <= 1'b0;
			sdat_s2_q <= 1'b0;
		end else if (ce_i) begin
			sdat_s1_q <= prog_serial_data_i;
			sdat_s2_q <= sdat_s1_q;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// step sequencing; the device answers nothing during erase, so
	// the bulk wait is simply time spent with the data line low
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			mst_q <= M_IDLE;
			idx_q <= '0;
		end else if (ce_i) begin
			unique case (mst_q)
				M_IDLE: if (go_ok) begin
					idx_q <= '0;
					mst_q <= M_ISSUE;
				end
				M_ISSUE: mst_q <= M_WAIT;
				M_WAIT: if (sh_done) begin
					if (st_last) begin
						mst_q <= M_FIN;
					end else begin
						idx_q <= idx_q + 4'h1;
						mst_q <= M_ISSUE;
					end
				end
				M_FIN: mst_q <= M_IDLE;
			endcase
		end
	end

	assign sh_start = (mst_q == M_ISSUE);

	// step table: command, payload, timed high, low phase, last
	always_comb begin
		st_cmd  = sfes_pkg::CMD_CORE;
		st_pay  = sfes_pkg::INS_NOP;
		st_ext  = 1'b0;
		st_lo   = sfes_pkg::LO_HALF;
		st_last = 1'b0;
		unique case (op_q)
			sfes_pkg::OP_BULK: begin
				if (idx_q < 4'h6)
					st_pay = ptr_load(idx_q, sfes_pkg::ADDR_ERASE_SEL);
				else if (idx_q == 4'h6) begin
					st_cmd = sfes_pkg::CMD_TWRITE;
					st_pay = {sfes_pkg::ZERO_BYTE, opt_q};
				end else if (idx_q == 4'h7)
					st_lo = sfes_pkg::LO_BULK;
				else
					st_last = 1'b1;
			end
			sfes_pkg::OP_SETUP: begin
				unique case (idx_q)
					4'h0:    st_pay = sfes_pkg::INS_SET_FLSH;
					4'h1:    st_pay = sfes_pkg::INS_SET_CFG;
					4'h2:    st_pay = sfes_pkg::INS_SET_WRAL;
					4'h9: begin
						st_cmd = sfes_pkg::CMD_TWRITE;
						st_pay = {sfes_pkg::ZERO_BYTE, sfes_pkg::PANEL_ENABLE};
					end
					4'ha:    st_pay = sfes_pkg::INS_SET_FLSH;
					4'hb:    st_pay = sfes_pkg::INS_CLR_CFG;
					4'hc:    st_pay = {sfes_pkg::OPC_CLRF, sfes_pkg::REG_PTR_U};
					4'hd:    st_pay = {sfes_pkg::OPC_CLRF, sfes_pkg::REG_PTR_H};
					4'he: begin
						st_pay  = {sfes_pkg::OPC_CLRF, sfes_pkg::REG_PTR_L};
						st_last = 1'b1;
					end
					default: st_pay = ptr_load(idx_q - 4'h3,
						sfes_pkg::ADDR_PANEL_CTRL);
				endcase
			end
			default: begin
				if (idx_q < 4'h6)
					st_pay = ptr_load(idx_q, row_q);
				else if (idx_q == 4'h6)
					st_pay = sfes_pkg::INS_SET_ROWE;
				else if (idx_q == 4'h7)
					st_cmd = sfes_pkg::CMD_TWRITE_PRG;
				else begin
					st_ext  = 1'b1;
					st_lo   = sfes_pkg::LO_DISCH;
					st_last = 1'b1;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// serial engine
	// ------------------------------------------------------------
	sfes_shift #(
		.HOLD_CYC (PROG_HOLD_CYC),
		.BULK_CYC (BULK_CYC)
	) u_shift (
		.mclk_i    (mclk_i),
		.nrst_i    (nrst_i),
		.ce_i      (ce_i),
		.start_i   (sh_start),
		.cmd_i     (st_cmd),
		.payload_i (st_pay),
		.ext_hi_i  (st_ext),
		.lo_sel_i  (st_lo),
		.busy_o    (sh_busy),
		.done_o    (sh_done),
		.sclk_o    (prog_serial_clock_o),
		.sdat_o    (prog_serial_data_o),
		.sdat_oe_o (prog_serial_data_oe_o)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_bulk_write;
		sh_start && op_q == sfes_pkg::OP_BULK
			&& st_cmd == sfes_pkg::CMD_TWRITE;
	endsequence
	sequence s_timed_nop;
		sh_start && st_ext;
	endsequence

	property p_bulk_write;
		s_bulk_write |-> st_pay == {sfes_pkg::ZERO_BYTE, opt_q}
			&& opt_ok(opt_q) && idx_q == 4'h6;
	endproperty
	a_bulk_write: assert property (p_bulk_write)
		else $error("bulk erase table write carries wrong option");

	property p_timed_nop;
		s_timed_nop |-> st_cmd == sfes_pkg::CMD_CORE
			&& st_pay == sfes_pkg::INS_NOP && st_lo == sfes_pkg::LO_DISCH
			&& op_q == sfes_pkg::OP_ROW && $past(st_cmd, 2)
			== sfes_pkg::CMD_TWRITE_PRG;
	endproperty
	a_timed_nop: assert property (p_timed_nop)
		else $error("held no-op not after start programming");

	property p_row_step;
		(ce_i && mst_q == M_FIN && op_q == sfes_pkg::OP_ROW)
			|=> row_q == $past(row_q) + sfes_pkg::ROW_STEP;
	endproperty
	a_row_step: assert property (p_row_step)
		else $error("row pointer did not advance by one row");

	property p_no_restart;
		(busy && acc_wr && avs_address_i == sfes_pkg::REG_CTRL)
			|=> $stable(op_q);
	endproperty
	a_no_restart: assert property (p_no_restart)
		else $error("operation changed while sequence busy");

	property p_issue;
		(ce_i && mst_q == M_ISSUE) |=> sh_busy ##1 mst_q == M_WAIT;
	endproperty
	a_issue: assert property (p_issue)
		else $error("issued word did not start the shifter");

endmodule

// ==== shared/sfes_pkg.sv ====
package sfes_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ       = 25;
	localparam int SCLK_HALF_NS  = 160;
	localparam int PROG_HOLD_US  = 1000;
	localparam int DISCHARGE_US  = 5;
	localparam int BULK_ERASE_US = 5000;
	localparam int CW            = 24;
	// least times, so rounded up to whole cycles
	localparam logic [CW-1:0] HALF_CYC  =
		CW'((SCLK_HALF_NS * CLK_MHZ + 999) / 1000);
	localparam logic [CW-1:0] DISCH_CYC = CW'(DISCHARGE_US * CLK_MHZ);
	localparam logic [CW-1:0] CNT_ONE   = CW'(1);

	// ------------------------------------------------------------
	// serial framing and commands
	// ------------------------------------------------------------
	localparam int         WORD_BITS      = 20;
	localparam int         CMD_BITS       = 4;
	localparam logic [4:0] LAST_BIT       = 5'(WORD_BITS - 1);
	localparam logic [4:0] TIMED_BIT      = 5'(CMD_BITS - 1);
	localparam logic [3:0] CMD_CORE       = 4'h0;
	localparam logic [3:0] CMD_TWRITE     = 4'hc;
	localparam logic [3:0] CMD_TWRITE_PRG = 4'hf;

	// ------------------------------------------------------------
	// core instruction payloads
	// ------------------------------------------------------------
	localparam logic [7:0]  OPC_MOVLW    = 8'h0e;
	localparam logic [7:0]  OPC_MOVWF    = 8'h6e;
	localparam logic [7:0]  OPC_CLRF     = 8'h6a;
	localparam logic [7:0]  REG_PTR_U    = 8'hf8;
	localparam logic [7:0]  REG_PTR_H    = 8'hf7;
	localparam logic [7:0]  REG_PTR_L    = 8'hf6;
	localparam logic [15:0] INS_NOP      = 16'h0000;
	localparam logic [15:0] INS_SET_FLSH = 16'h8ea6;
	localparam logic [15:0] INS_SET_CFG  = 16'h8ca6;
	localparam logic [15:0] INS_SET_WRAL = 16'h84a6;
	localparam logic [15:0] INS_CLR_CFG  = 16'h9ca6;
	localparam logic [15:0] INS_SET_ROWE = 16'h88a6;

	// ------------------------------------------------------------
	// device locations and erase option codes
	// ------------------------------------------------------------
	localparam logic [21:0] ADDR_ERASE_SEL  = 22'h3c0004;
	localparam logic [21:0] ADDR_PANEL_CTRL = 22'h3c0006;
	localparam logic [7:0]  PANEL_ENABLE    = 8'h40;
	localparam logic [7:0]  ZERO_BYTE       = 8'h00;
	localparam logic [21:0] ROW_STEP        = 22'h000040;
	localparam logic [7:0]  OPT_CHIP        = 8'h80;
	localparam logic [7:0]  OPT_DATA        = 8'h81;
	localparam logic [7:0]  OPT_BOOT        = 8'h83;
	localparam logic [7:0]  OPT_BLK_FIRST   = 8'h88;
	localparam logic [7:0]  OPT_BLK_LAST    = 8'h8f;

	// ------------------------------------------------------------
	// low-phase selectors, operations, registers
	// ------------------------------------------------------------
	localparam logic [1:0] LO_HALF  = 2'h0;
	localparam logic [1:0] LO_DISCH = 2'h1;
	localparam logic [1:0] LO_BULK  = 2'h2;
	localparam logic [1:0] OP_BULK  = 2'h0;
	localparam logic [1:0] OP_SETUP = 2'h1;
	localparam logic [1:0] OP_ROW   = 2'h2;
	localparam logic [2:0] REG_CTRL   = 3'h0;
	localparam logic [2:0] REG_OPTION = 3'h1;
	localparam logic [2:0] REG_ROW    = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam int         ST_ERR     = 1;
	localparam logic [7:0] OPTION_RST = 8'h80;

endpackage

// ==== core/sfes_shift.sv ====
`timescale 1ns/1ps
module sfes_shift #(
	parameter logic [sfes_pkg::CW-1:0] HOLD_CYC = sfes_pkg::HALF_CYC,
	parameter logic [sfes_pkg::CW-1:0] BULK_CYC = sfes_pkg::HALF_CYC
)(
	// clock, reset, enable
	input  wire logic        mclk_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	// word request
	input  wire logic        start_i,
	input  wire logic [3:0]  cmd_i,
	input  wire logic [15:0] payload_i,
	input  wire logic        ext_hi_i,
	input  wire logic [1:0]  lo_sel_i,
	output logic             busy_o,
	output logic             done_o,
	// serial pins
	output logic             sclk_o,
	output logic             sdat_o,
	output logic             sdat_oe_o
);

	// ------------------------------------------------------------
	// word shifter
	// ------------------------------------------------------------
	typedef enum logic [1:0] {S_IDLE, S_HI, S_LO} sfes_sh_t;

	sfes_sh_t                 st_q;
	logic [19:0]              sr_q;
	logic [4:0]               bit_q;
	logic [sfes_pkg::CW-1:0]  cnt_q;
	logic                     ext_q;
	logic [1:0]               lo_q;
	logic                     sclk_q;
	logic                     sdat_q;
	logic                     oe_q;
	logic                     done_q;

	function automatic logic [sfes_pkg::CW-1:0] hi_len(
		input logic [4:0] b, input logic e);
		hi_len = (b == sfes_pkg::TIMED_BIT && e) ? HOLD_CYC
			: sfes_pkg::HALF_CYC;
	endfunction

	function automatic logic [sfes_pkg::CW-1:0] lo_len(
		input logic [4:0] b, input logic [1:0] s);
		lo_len = sfes_pkg::HALF_CYC;
		if (b == sfes_pkg::TIMED_BIT && s == sfes_pkg::LO_DISCH)
			lo_len = sfes_pkg::DISCH_CYC;
		if (b == sfes_pkg::TIMED_BIT && s == sfes_pkg::LO_BULK)
			lo_len = BULK_CYC;
	endfunction

	// data moves with the rising clock so it is settled at the fall
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			st_q   <= S_IDLE;
			sr_q   <= '0;
			bit_q  <= '0;
			cnt_q  <= '0;
			ext_q  <= 1'b0;
			lo_q   <= sfes_pkg::LO_HALF;
			sclk_q <= 1'b0;
			sdat_q <= 1'b0;
			oe_q   <= 1'b0;
			done_q <= 1'b0;
		end else if (ce_i) begin
			done_q <= 1'b0;
			unique case (st_q)
				S_IDLE: if (start_i) begin
					sr_q   <= {payload_i, cmd_i};
					bit_q  <= '0;
					ext_q  <= ext_hi_i;
					lo_q   <= lo_sel_i;
					sclk_q <= 1'b1;
					sdat_q <= cmd_i[0];
					oe_q   <= 1'b1;
					cnt_q  <= hi_len('0, ext_hi_i);
					st_q   <= S_HI;
				end
				S_HI: if (cnt_q == sfes_pkg::CNT_ONE) begin
					sclk_q <= 1'b0;
					cnt_q  <= lo_len(bit_q, lo_q);
					st_q   <= S_LO;
				end else begin
					cnt_q <= cnt_q - sfes_pkg::CNT_ONE;
				end
				S_LO: if (cnt_q == sfes_pkg::CNT_ONE) begin
					if (bit_q == sfes_pkg::LAST_BIT) begin
						st_q   <= S_IDLE;
						done_q <= 1'b1;
						sdat_q <= 1'b0; // idle low, safe during erase
					end else begin
						bit_q  <= bit_q + 5'h1;
						sr_q   <= sr_q >> 1;
						sdat_q <= sr_q[1];
						sclk_q <= 1'b1;
						cnt_q  <= hi_len(bit_q + 5'h1, ext_q);
						st_q   <= S_HI;
					end
				end else begin
					cnt_q <= cnt_q - sfes_pkg::CNT_ONE;
				end
			endcase
		end
	end

	assign busy_o    = (st_q != S_IDLE);
	assign done_o    = done_q;
	assign sclk_o    = sclk_q;
	assign sdat_o    = sdat_q;
	assign sdat_oe_o = oe_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [sfes_pkg::CW-1:0] len_q;
	logic                    sclk_d1_q;
	logic [4:0]              nfall_q;

	// phase length seen from the pin, falling-edge count taken from the shifter state
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			len_q     <= '0;
			sclk_d1_q <= 1'b0;
			nfall_q   <= '0;
		end else if (ce_i) begin
			sclk_d1_q <= sclk_q;
			len_q     <= (sclk_q != sclk_d1_q) ? sfes_pkg::CNT_ONE
				: len_q + sfes_pkg::CNT_ONE;
			if (st_q == S_IDLE && start_i)
				nfall_q <= '0;
			else if (st_q == S_HI && cnt_q == sfes_pkg::CNT_ONE)
				nfall_q <= nfall_q + 5'h1;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_go;
		ce_i && st_q == S_IDLE && start_i;
	endsequence
	sequence s_timed_fall;
		$fell(sclk_q) && bit_q == sfes_pkg::TIMED_BIT && ext_q;
	endsequence

	property p_lsb_first;
		s_go |=> sclk_o && sdat_o == $past(cmd_i[0]);
	endproperty
	a_lsb_first: assert property (p_lsb_first)
		else $error("first bit out is not command bit zero");

	property p_hold_low;
		(st_q == S_LO && $past(st_q) == S_LO) |-> $stable(sdat_q);
	endproperty
	a_hold_low: assert property (p_hold_low)
		else $error("data changed while serial clock low");

	property p_hold_hi;
		s_timed_fall |-> len_q == HOLD_CYC;
	endproperty
	a_hold_hi: assert property (p_hold_hi)
		else $error("timed high phase has wrong length");

	property p_discharge;
		($rose(sclk_q) && bit_q == sfes_pkg::TIMED_BIT + 5'h1
			&& lo_q == sfes_pkg::LO_DISCH) |-> len_q == sfes_pkg::DISCH_CYC;
	endproperty
	a_discharge: assert property (p_discharge)
		else $error("discharge low phase has wrong length");

	property p_bulk_low;
		(st_q == S_LO && bit_q == sfes_pkg::TIMED_BIT
			&& lo_q == sfes_pkg::LO_BULK) |-> !sdat_o && sdat_oe_o;
	endproperty
	a_bulk_low: assert property (p_bulk_low)
		else $error("data not held low during bulk erase");

	property p_twenty;
		done_q |-> nfall_q == 5'(sfes_pkg::WORD_BITS);
	endproperty
	a_twenty: assert property (p_twenty)
		else $error("word did not carry twenty clocks");

endmodule

// ==== sim/sfes_dev_model.sv ====
`timescale 1ns/1ps
module sfes_dev_model #(
	parameter int BULK = 30
)(
	// clock, reset
	input  wire logic   mclk_i,
	input  wire logic   nrst_i,
	// pins
	input  wire logic   sclk_i,
	input  wire logic   sdat_i,
	// what the device saw
	output logic        wv_o,
	output logic [19:0] w_o,
	output int          hi_o,
	output int          lo_o,
	output logic [7:0]  sel_o,
	output logic [7:0]  pan_o,
	output int          rows_o,
	output logic        viol_o,
	// protection per region: data, boot, blocks one to eight
	output logic [9:0]  prot_o
);
	logic [19:0] sh;
	logic [21:0] ptr;
	logic [7:0]  lit;
	logic        ck, arm, row;
	int          nb, hc, lc, bsy;
	wire  [19:0] w   = {sdat_i, sh[19:1]};
	wire  [7:0]  v   = w[14] ? lit : 8'h00;
	wire         ok  = w[11:4] inside {8'h80, 8'h81, 8'h83, [8'h88:8'h8f]};
	wire         pan = pan_o == 8'h40;
	// pins sampled by our clock; phase lengths counted in cycles
	always @(posedge mclk_i) begin
		ck   <= sclk_i;
		wv_o <= 1'b0;
		if (!nrst_i) begin
			{nb, bsy, arm, row, rows_o, viol_o} <= '0;
			{ptr, sel_o, pan_o} <= '0;
			prot_o <= '1;
		end else if (bsy > 0) begin
			bsy    <= bsy - 1;
			lc     <= lc + 1;
			viol_o <= viol_o | sdat_i;
		end else if (sclk_i) begin
			hc <= ck ? hc + 1 : 1;
			if (!ck && nb == 4) lo_o <= lc;
		end else if (!ck) begin
			lc <= lc + 1;
		end else begin
			// bit taken at the fall, lsb first
			sh <= w;
			lc <= 1;
			nb <= (nb == 19) ? 0 : nb + 1;
			if (nb == 3) begin
				hi_o <= hc;
				arm  <= 1'b0;
				row  <= 1'b0;
				if (arm && w[19:16] == 4'h0) begin
					bsy <= BULK;
					// only a bulk erase lifts protection, per region
					case (sel_o)
						8'h80: prot_o <= '0;
						8'h81: prot_o[0] <= 1'b0;
						8'h83: prot_o[1] <= 1'b0;
						default: prot_o[sel_o[2:0] + 2] <= 1'b0;
					endcase
				end
				if (row && pan) rows_o <= rows_o + 1;
			end
			if (nb == 19) begin
				wv_o <= 1'b1;
				w_o  <= w;
				row  <= w[3:0] == 4'hf;
				if (w[3:0] == 4'h0 && w[19:12] == 8'h0e) lit <= w[11:4];
				// pointer bytes: literal move or clear
				if (w[3:0] == 4'h0 && (w[19:12] | 8'h04) == 8'h6e) begin
					case (w[11:4])
						8'hf8: ptr[21:16] <= v[5:0];
						8'hf7: ptr[15:8] <= v;
						8'hf6: ptr[7:0] <= v;
						default: ;
					endcase
				end
				if (w[3:0] == 4'hc && ptr == 22'h3c0004) begin
					sel_o <= w[11:4];
					arm   <= ok;
				end
				if (w[3:0] == 4'hc && ptr == 22'h3c0006) pan_o <= w[11:4];
			end
		end
	end
endmodule

// ==== sim/sfes_host_tb.sv ====
`timescale 1ns/1ps
module sfes_host_tb;
	localparam int          HC = sfes_pkg::HALF_CYC;
	localparam logic [31:0] RST[5] = '{32'h0, 32'h80, 32'h0, 32'h0, 32'h0};
	localparam logic [15:0] SU1[3] = '{16'h8ea6, 16'h8ca6, 16'h84a6};
	localparam logic [15:0] SU2[5] =
		'{16'h8ea6, 16'h9ca6, 16'h6af8, 16'h6af7, 16'h6af6};
	logic        mclk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        ce     = 1'b1;
	logic [9:0]  prot, pe;
	logic        rd     = 1'b0;
	logic        wr     = 1'b0;
	logic [2:0]  adr    = 3'h0;
	logic [31:0] wd     = 32'h0;
	logic [31:0] rdat, q;
	logic        wreq, sclk, sdat, soe, wv, viol;
	logic [19:0] w;
	logic [7:0]  sel, pan, o;
	logic [21:0] r;
	logic [43:0] e;
	logic [43:0] exp_q[$];
	int          hi, lo, rows, n, j;
	int          fail_count = 0;
	int          cmp_count  = 0;
	// weak pull-down holds the data line while undriven
	wire         pin = soe & sdat;

	always #20 mclk_i = ~mclk_i;

	sfes_host #(
		.PROG_HOLD_CYC(sfes_pkg::CW'(20)),
		.BULK_CYC     (sfes_pkg::CW'(30))
	) dut_u (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .prog_serial_clock_o(sclk),
		.prog_serial_data_o(sdat), .prog_serial_data_oe_o(soe),
		.prog_serial_data_i(pin)
	);
	// device erase shorter than the host's wait, as the host must outlast it
	sfes_dev_model #(.BULK(24)) dev_u (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk), .sdat_i(pin),
		.wv_o(wv), .w_o(w), .hi_o(hi), .lo_o(lo), .sel_o(sel),
		.pan_o(pan), .rows_o(rows), .viol_o(viol), .prot_o(prot)
	);

	task automatic chk(input string s, input logic [31:0] v, x);
		cmp_count++;
		if (v !== x) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", s, x, v);
		end
	endtask
	task automatic tally_and_finish;
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// request held until the edge at which waitrequest is low
	task automatic av(input logic rw, input logic [2:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk_i);
		rd  <= !rw;
		wr  <= rw;
		adr <= a;
		wd  <= d;
		k = 0;
		do begin
			@(posedge mclk_i);
			k++;
		end while (wreq !== 1'b0 && k < 99);
		// taken at the edge that sees waitrequest low, released at once
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 99) begin
			fail_count++;
			tally_and_finish();
		end
	endtask
	// status bit 2 follows the data pin, so it is masked
	task automatic rchk(input logic [2:0] a, input logic [31:0] x);
		av(1'b0, a, 32'h0);
		chk("reg", q & 32'hfffffffb, x);
	endtask
	task automatic push(input logic [3:0] c, input logic [15:0] p,
		input int h = HC, input int l = HC);
		exp_q.push_back({12'(h), 12'(l), p, c});
	endtask
	task automatic pptr(input logic [21:0] a);
		push(4'h0, {8'h0e, 2'b00, a[21:16]});
		push(4'h0, 16'h6ef8);
		push(4'h0, {8'h0e, a[15:8]});
		push(4'h0, 16'h6ef7);
		push(4'h0, {8'h0e, a[7:0]});
		push(4'h0, 16'h6ef6);
	endtask
	task automatic idle;
		n = 0;
		do begin
			av(1'b0, 3'h3, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 2000);
		chk("words left", exp_q.size(), 0);
		chk("pin", q[2], 0);
		if (n >= 2000) begin
			fail_count++;
			tally_and_finish();
		end
	endtask

	// each word the device took, against the expected sequence
	always @(posedge mclk_i) begin
		if (wv) begin
			e = exp_q.size() ? exp_q.pop_front() : '1;
			chk("word", w, e[19:0]);
			chk("high", hi >= e[43:32], 1);
			chk("low", lo >= e[31:20], 1);
		end
	end

	initial begin
		void'($urandom(32'hdfed76da));
		repeat (20) @(posedge mclk_i);
		nrst_i <= 1'b1;
		foreach (RST[i]) rchk(3'(i), RST[i]);
		av(1'b1, 3'h5, 32'hffffffff);
		rchk(3'h5, 32'h0);
		// refusals: row before setup, then an invalid option
		av(1'b1, 3'h0, 32'h2);
		rchk(3'h3, 32'h2);
		av(1'b1, 3'h3, 32'h2);
		av(1'b1, 3'h1, 32'($urandom) & 32'h7f);
		av(1'b1, 3'h0, 32'h0);
		rchk(3'h3, 32'h2);
		av(1'b1, 3'h3, 32'h2);
		// 81 83, then 88 to 8f, then 80
		pe = 10'h3ff;
		chk("protect", prot, pe);
		// chip erase last, so each region clears on its own first
		for (int i = 0; i < 11; i++) begin
			j = (i + 1) % 11;
			o = (j < 3) ? 8'(8'h80 + j + (j == 2)) : 8'(8'h85 + j);
			av(1'b1, 3'h1, {24'h0, o});
			pptr(22'h3c0004);
			push(4'hc, {8'h00, o});
			push(4'h0, 16'h0000, HC, 30);
			push(4'h0, 16'h0000);
			av(1'b1, 3'h0, 32'h0);
			av(1'b1, 3'h0, 32'h1);
			rchk(3'h3, 32'h1);
			idle();
			chk("option", sel, o);
			pe = (o == 8'h80) ? 10'h0 : pe & ~(10'h1 << ((o == 8'h81) ? 0
				: (o == 8'h83) ? 1 : o - 8'h86));
			chk("protect", prot, pe);
		end
		chk("data held", viol, 0);
		av(1'b1, 3'h0, 32'h1);
		foreach (SU1[i]) push(4'h0, SU1[i]);
		pptr(22'h3c0006);
		push(4'hc, 16'h0040);
		foreach (SU2[i]) push(4'h0, SU2[i]);
		idle();
		chk("panel", pan, 8'h40);
		rchk(3'h3, 32'h8);
		r = 22'($urandom) & 22'h3fffc0;
		av(1'b1, 3'h2, {10'h0, r});
		for (int k = 0; k < 2; k++) begin
			pptr(r);
			push(4'h0, 16'h88a6);
			push(4'hf, 16'h0000);
			push(4'h0, 16'h0000, 20, 125);
			av(1'b1, 3'h0, 32'h2);
			// freeze the block as the first word is issued; words must come out whole
			if (k == 1) begin
				ce <= 1'b0;
				repeat (37) @(posedge mclk_i);
				ce <= 1'b1;
			end
			av(1'b1, 3'h2, 32'h0);
			idle();
			r = r + 22'h40;
			rchk(3'h2, {10'h0, r});
		end
		chk("rows", rows, 2);
		rchk(3'h0, 32'h2);
		tally_and_finish();
	end
endmodule
